// ### hdl/mrs_defines.svh
// Command codes, exception codes, frame lengths and link timing of the RTU link.
// Assumes a 250 MHz core clock; included by the package and by both ends.
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

`define MRS_CMD_RD       8'h03
`define MRS_CMD_WR1      8'h06
`define MRS_CMD_WRN      8'h10
`define MRS_CMD_WR1_NV   8'h41
`define MRS_CMD_WRN_NV   8'h43
`define MRS_EXC_FLAG     8'h80
`define MRS_ADDR_BCAST   8'h00

`define MRS_CRC_INIT     16'hFFFF
`define MRS_CRC_POLY     16'hA001
`define MRS_CNT_MIN      16'h0001
`define MRS_CNT_MAX      16'h000A

`define MRS_GRP_STD_MAX  8'h10
`define MRS_GRP_18       8'h12
`define MRS_GRP_19       8'h13
`define MRS_GRP_23       8'h17
`define MRS_GRP_CTRL     8'h64
`define MRS_GRP_STAT     8'h65

`define MRS_EX_NONE      8'h00
`define MRS_EX_CMD       8'h01
`define MRS_EX_ADDR      8'h02
`define MRS_EX_DATA      8'h03
`define MRS_EX_FAIL      8'h04
`define MRS_EX_PROG      8'h05
`define MRS_EX_BUSY      8'h06
`define MRS_EX_UNSUP     8'h16
`define MRS_EX_COUNT     8'h17
`define MRS_EX_FRAME     8'h18
`define MRS_EX_RO        8'h20
`define MRS_EX_RUN       8'h21
`define MRS_EX_PWD       8'h22

`define MRS_FRAME_MAX    32
`define MRS_LEN_MIN      4
`define MRS_LEN_FIX      8
`define MRS_LEN_WRN      9
`define MRS_RSP_MIN      5

`define MRS_CLK_HZ       250000000
`define MRS_BAUD         9600
`define MRS_START_BITS   1
`define MRS_DATA_BITS    8
`define MRS_STOP_BITS    2
`define MRS_CHAR_BITS    (`MRS_START_BITS + `MRS_DATA_BITS + `MRS_STOP_BITS)
`define MRS_GAP_TENTHS   35
`define MRS_GAP_CYCLES   ((64'(`MRS_GAP_TENTHS) * `MRS_CHAR_BITS * `MRS_CLK_HZ + \
	64'(10 * `MRS_BAUD) - 1) / 64'(10 * `MRS_BAUD))

`endif

// ### hdl/mrs_link_if.sv
// Byte-level link between the host end and the drive end of the RTU bus.
// Assumes character timing is done outside; one valid cycle carries one character.
`timescale 1ns/1ps
interface mrs_link_if;
	logic       h2d_valid;
	logic [7:0] h2d_byte;
	logic       d2h_valid;
	logic [7:0] d2h_byte;

	modport dev
	(
		input  h2d_valid,
		input  h2d_byte,
		output d2h_valid,
		output d2h_byte
	);

	modport host
	(
		input  d2h_valid,
		input  d2h_byte,
		output h2d_valid,
		output h2d_byte
	);
endinterface

// ### hdl/mrs_master.sv
// Host end of the RTU link: sends one request, collects and checks the answer.
// Assumes the user holds request fields stable while o_req_ready and i_req_valid meet.
`timescale 1ns/1ps
`include "mrs_defines.svh"
module mrs_master
	import mrs_pkg::*;
#(
	parameter int unsigned GAP_CYCLES  = 32'(`MRS_GAP_CYCLES),
	parameter int unsigned RSP_TIMEOUT = 32'(2 * `MRS_GAP_CYCLES)
)(
	input  logic         i_core_clk,
	input  logic         i_reset,
	mrs_link_if.host     link,
	input  logic         i_req_valid,
	output logic         o_req_ready,
	input  logic [7:0]   i_req_slave,
	input  logic [7:0]   i_req_cmd,
	input  logic [15:0]  i_req_addr,
	input  logic [15:0]  i_req_cnt,
	input  logic [159:0] i_req_data,
	output logic         o_rd_valid,
	output logic [15:0]  o_rd_data,
	output logic         o_done,
	output logic [7:0]   o_exc,
	output logic         o_no_reply,
	output logic         o_bad_reply
);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam int TW = $clog2(RSP_TIMEOUT + 1);
	localparam int FM = `MRS_FRAME_MAX;

	mrs_host_state_t state_q;
	logic [GW-1:0]   idle_q;
	logic [TW-1:0]   tmo_q;
	logic [7:0]      slave_q;
	logic [7:0]      cmd_q;
	logic [15:0]     addr_q;
	logic [15:0]     cnt_q;
	logic [159:0]    data_q;
	logic [5:0]      tx_len_q;
	logic [5:0]      tx_idx_q;
	logic [15:0]     tx_crc_q;
	logic [7:0]      rb [0:FM-1];
	logic [5:0]      rx_len_q;
	logic [15:0]     rx_crc_q;
	logic [3:0]      out_q;
	logic            h2d_valid_q;
	logic [7:0]      h2d_byte_q;
	logic [7:0]      pb;
	logic [4:0]      k;

	wire gap_done  = (idle_q == GW'(GAP_CYCLES));
	wire is_wn     = (i_req_cmd == `MRS_CMD_WRN) || (i_req_cmd == `MRS_CMD_WRN_NV);
	wire cnt_req   = is_wn || (i_req_cmd == `MRS_CMD_RD);
	wire cnt_bad   = cnt_req && (i_req_cnt < `MRS_CNT_MIN || i_req_cnt > `MRS_CNT_MAX);
	wire take      = (state_q == H_IDLE) && o_req_ready && i_req_valid;
	wire frame_end = (state_q == H_WAIT) && (rx_len_q != 6'h00) && gap_done;
	wire rsp_ok    = (rx_crc_q == 16'h0000) && (rx_len_q >= 6'(`MRS_RSP_MIN)) &&
		(rb[0] == slave_q) && (rb[1][6:0] == cmd_q[6:0]);
	wire rsp_exc   = rb[1][7];
	wire rd_ok     = (cmd_q == `MRS_CMD_RD) && (rb[2] == {cnt_q[6:0], 1'b0}) &&
		(rx_len_q == 6'(`MRS_RSP_MIN) + 6'(rb[2]));
	wire no_rsp    = (slave_q == `MRS_ADDR_BCAST) || (tmo_q == TW'(RSP_TIMEOUT));
	wire [47:0] hdr = {slave_q, cmd_q, addr_q, cnt_q};

	assign link.h2d_valid = h2d_valid_q;
	assign link.h2d_byte  = h2d_byte_q;

	always_ff @(posedge i_core_clk)
		if (i_reset)
			idle_q <= '0;
		else if (link.d2h_valid || h2d_valid_q)
			idle_q <= '0;
		else if (!gap_done)
			idle_q <= idle_q + 1'b1;

	// Request byte at the current send position, high byte first.
	always_comb
	begin
		k  = 5'(tx_idx_q - 6'h07);
		pb = {cnt_q[6:0], 1'b0};
		if (tx_idx_q < 6'h06)
			pb = hdr[6'd47 - {tx_idx_q[2:0], 3'b000} -: 8];
		else if (tx_idx_q > 6'h06)
			pb = data_q[{k[4:1], ~k[0], 3'b000} +: 8];
	end

	always_ff @(posedge i_core_clk)
		if (i_reset)
		begin
			state_q     <= H_IDLE;
			o_req_ready <= 1'b0;
			slave_q     <= 8'h00;
			cmd_q       <= 8'h00;
			addr_q      <= 16'h0000;
			cnt_q       <= 16'h0000;
			data_q      <= '0;
			tx_len_q    <= 6'h00;
			out_q       <= 4'h0;
			o_done      <= 1'b0;
			o_exc       <= 8'h00;
			o_no_reply  <= 1'b0;
			o_bad_reply <= 1'b0;
			o_rd_valid  <= 1'b0;
			o_rd_data   <= 16'h0000;
		end
		else
		begin
			o_done      <= 1'b0;
			o_no_reply  <= 1'b0;
			o_bad_reply <= 1'b0;
			o_rd_valid  <= 1'b0;
			o_req_ready <= (state_q == H_IDLE) && gap_done && !take;
			case (state_q)
				H_IDLE:
					if (take && cnt_bad)
					begin
						o_done <= 1'b1;
						o_exc  <= `MRS_EX_DATA;
					end
					else if (take)
					begin
						slave_q  <= i_req_slave;
						cmd_q    <= i_req_cmd;
						addr_q   <= i_req_addr;
						cnt_q    <= i_req_cnt;
						data_q   <= i_req_data;
						tx_len_q <= is_wn ? 6'(`MRS_LEN_WRN - 2 + 2 * i_req_cnt[3:0]) :
							6'(`MRS_LEN_FIX - 2);
						o_exc    <= `MRS_EX_NONE;
						state_q  <= H_TX;
					end
				H_TX:
					if (tx_idx_q == tx_len_q + 6'h01)
						state_q <= H_WAIT;
				H_WAIT:
					if (frame_end && (!rsp_ok || (!rsp_exc && cmd_q == `MRS_CMD_RD && !rd_ok)))
					begin
						o_bad_reply <= 1'b1;
						o_done      <= 1'b1;
						state_q     <= H_IDLE;
					end
					else if (frame_end && !rsp_exc && cmd_q == `MRS_CMD_RD)
					begin
						out_q   <= 4'h0;
						state_q <= H_OUT;
					end
					else if (frame_end)
					begin
						o_exc   <= rsp_exc ? rb[2] : `MRS_EX_NONE;
						o_done  <= 1'b1;
						state_q <= H_IDLE;
					end
					else if (rx_len_q == 6'h00 && gap_done && no_rsp)
					begin
						o_no_reply <= 1'b1;
						o_done     <= 1'b1;
						state_q    <= H_IDLE;
					end
				H_OUT:
				begin
					o_rd_valid <= 1'b1;
					o_rd_data  <= {rb[5'(3 + 2 * out_q)], rb[5'(4 + 2 * out_q)]};
					out_q      <= out_q + 4'h1;
					if (out_q == cnt_q[3:0] - 4'h1)
					begin
						o_done  <= 1'b1;
						state_q <= H_IDLE;
					end
				end
				default:
					state_q <= H_IDLE;
			endcase
		end

	always_ff @(posedge i_core_clk)
		if (i_reset || state_q != H_TX)
		begin
			tx_idx_q    <= 6'h00;
			tx_crc_q    <= `MRS_CRC_INIT;
			h2d_valid_q <= 1'b0;
			h2d_byte_q  <= 8'h00;
		end
		else
		begin
			h2d_valid_q <= 1'b1;
			tx_idx_q    <= tx_idx_q + 6'h01;
			if (tx_idx_q < tx_len_q)
			begin
				h2d_byte_q <= pb;
				tx_crc_q   <= mrs_crc_step(tx_crc_q, pb);
			end
			else if (tx_idx_q == tx_len_q)
				h2d_byte_q <= tx_crc_q[7:0];
			else
				h2d_byte_q <= tx_crc_q[15:8];
		end

	// The timeout counter counts to RSP_TIMEOUT in H_WAIT and holds, but only ends the wait before the first answer character; broadcasts end at one gap.
	always_ff @(posedge i_core_clk)
		if (i_reset || state_q != H_WAIT)
		begin
			rx_len_q <= 6'h00;
			rx_crc_q <= `MRS_CRC_INIT;
			tmo_q    <= '0;
		end
		else
		begin
			if (tmo_q != TW'(RSP_TIMEOUT))
				tmo_q <= tmo_q + 1'b1;
			if (link.d2h_valid && rx_len_q != 6'(FM))
			begin
				rx_len_q <= rx_len_q + 6'h01;
				rx_crc_q <= mrs_crc_step(rx_crc_q, link.d2h_byte);
			end
		end

	always_ff @(posedge i_core_clk)
		if (state_q == H_WAIT && link.d2h_valid && rx_len_q < 6'(FM))
			rb[rx_len_q[4:0]] <= link.d2h_byte;
endmodule

// ### hdl/mrs_pkg.sv
// State types and the checksum step shared by both ends of the RTU link.
// Assumes the constants header is on the include path.
`include "mrs_defines.svh"
package mrs_pkg;
	typedef enum logic [3:0]
	{
		D_RX     = 4'h1,
		D_CHECK  = 4'h2,
		D_ACCESS = 4'h4,
		D_TX     = 4'h8
	} mrs_dev_state_t;

	typedef enum logic [3:0]
	{
		H_IDLE = 4'h1,
		H_TX   = 4'h2,
		H_WAIT = 4'h4,
		H_OUT  = 4'h8
	} mrs_host_state_t;

	// Reflected CRC-16, one byte per call, low bit first.
	function automatic logic [15:0] mrs_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ `MRS_CRC_POLY) : (c >> 1);
		return c;
	endfunction
endpackage

// ### hdl/mrs_slave.sv
// Drive end of the RTU link: frames, checks and answers parameter requests.
// Assumes a parameter store that acknowledges each access with one pulse.
`timescale 1ns/1ps
`include "mrs_defines.svh"
module mrs_slave
	import mrs_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = 32'(`MRS_GAP_CYCLES)
)(
	input  logic        i_core_clk,
	input  logic        i_reset,
	mrs_link_if.dev     link,
	input  logic [7:0]  i_slave_addr,
	input  logic        i_persist_select,
	output logic        o_par_req,
	output logic        o_par_we,
	output logic        o_par_nv,
	output logic [15:0] o_par_addr,
	output logic [15:0] o_par_wdata,
	input  logic        i_par_ack,
	input  logic [15:0] i_par_rdata,
	input  logic [7:0]  i_par_status,
	output logic        o_frame_drop
);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam int FM = `MRS_FRAME_MAX;

	mrs_dev_state_t state_q;
	logic [GW-1:0]  idle_q;
	logic [7:0]     rx_buf [0:FM-1];
	logic [7:0]     tx_buf [0:FM-1];
	logic [5:0]     rx_len_q;
	logic [15:0]    rx_crc_q;
	logic           drop_q;
	logic [5:0]     tx_len_q;
	logic [5:0]     tx_idx_q;
	logic [15:0]    tx_crc_q;
	logic [7:0]     cmd_q;
	logic [15:0]    base_q;
	logic [15:0]    cnt_q;
	logic [3:0]     acc_q;
	logic           wait_q;
	logic           d2h_valid_q;
	logic [7:0]     d2h_byte_q;
	logic [7:0]     exc_d;

	function automatic logic grp_ok(input logic [7:0] g);
		return (g <= `MRS_GRP_STD_MAX) || (g == `MRS_GRP_18) || (g == `MRS_GRP_19) ||
			(g == `MRS_GRP_23) || (g == `MRS_GRP_CTRL) || (g == `MRS_GRP_STAT);
	endfunction

	wire        gap_done  = (idle_q == GW'(GAP_CYCLES));
	wire        frame_end = (state_q == D_RX) && (rx_len_q != 6'h00) && gap_done;
	wire [7:0]  r_cmd     = rx_buf[1];
	wire [15:0] r_addr    = {rx_buf[2], rx_buf[3]};
	wire [15:0] r_cnt     = {rx_buf[4], rx_buf[5]};
	wire        is_rd     = (r_cmd == `MRS_CMD_RD);
	wire        is_w1     = (r_cmd == `MRS_CMD_WR1) || (r_cmd == `MRS_CMD_WR1_NV);
	wire        is_wn     = (r_cmd == `MRS_CMD_WRN) || (r_cmd == `MRS_CMD_WRN_NV);
	wire        cnt_ok    = (r_cnt >= `MRS_CNT_MIN) && (r_cnt <= `MRS_CNT_MAX);
	wire [5:0]  need_len  = is_wn ? 6'(`MRS_LEN_WRN + 2 * r_cnt[3:0]) : 6'(`MRS_LEN_FIX);
	wire        frame_ok  = !drop_q && (rx_crc_q == 16'h0000) &&
		(rx_len_q >= 6'(`MRS_LEN_MIN)) && (rx_buf[0] == i_slave_addr) &&
		(rx_buf[0] != `MRS_ADDR_BCAST);
	wire        q_rd      = (cmd_q == `MRS_CMD_RD);
	wire        q_w1      = (cmd_q == `MRS_CMD_WR1) || (cmd_q == `MRS_CMD_WR1_NV);
	wire        q_nv      = (cmd_q == `MRS_CMD_WR1_NV) || (cmd_q == `MRS_CMD_WRN_NV);
	wire        acc_done  = (state_q == D_ACCESS) && wait_q && i_par_ack;

	assign link.d2h_valid = d2h_valid_q;
	assign link.d2h_byte  = d2h_byte_q;

	// Silence counter sees both directions, so the drive's own answer also needs a gap.
	always_ff @(posedge i_core_clk)
		if (i_reset)
			idle_q <= '0;
		else if (link.h2d_valid || d2h_valid_q)
			idle_q <= '0;
		else if (!gap_done)
			idle_q <= idle_q + 1'b1;

	// Characters that arrive while a frame is processed are dropped; the bus is half duplex.
	always_ff @(posedge i_core_clk)
		if (i_reset || state_q != D_RX)
		begin
			rx_len_q <= 6'h00;
			rx_crc_q <= `MRS_CRC_INIT;
			drop_q   <= 1'b0;
		end
		else if (link.h2d_valid)
		begin
			if (rx_len_q == 6'h00 && !gap_done)
				drop_q <= 1'b1;
			if (rx_len_q == 6'(FM))
				drop_q <= 1'b1;
			else
				rx_len_q <= rx_len_q + 6'h01;
			rx_crc_q <= mrs_crc_step(rx_crc_q, link.h2d_byte);
		end

	always_ff @(posedge i_core_clk)
		if (state_q == D_RX && link.h2d_valid && rx_len_q < 6'(FM))
			rx_buf[rx_len_q[4:0]] <= link.h2d_byte;

	// Only RTU binary frames are decoded; an ASCII frame fails the checksum.
	always_comb
	begin
		exc_d = `MRS_EX_NONE;
		if (!(is_rd || is_w1 || is_wn))
			exc_d = `MRS_EX_CMD;
		else if ((is_rd || is_wn) && !cnt_ok)
			exc_d = `MRS_EX_DATA;
		else if (rx_len_q != need_len)
			exc_d = `MRS_EX_FRAME;
		else if (is_wn && rx_buf[6] != {r_cnt[6:0], 1'b0})
			exc_d = `MRS_EX_COUNT;
		else if (!grp_ok(r_addr[15:8]))
			exc_d = `MRS_EX_ADDR;
		else if (!is_rd && r_addr[15:8] == `MRS_GRP_STAT)
			exc_d = `MRS_EX_RO;
	end

	always_ff @(posedge i_core_clk)
		if (i_reset)
		begin
			state_q  <= D_RX;
			tx_len_q <= 6'h00;
			cmd_q    <= 8'h00;
			base_q   <= 16'h0000;
			cnt_q    <= 16'h0000;
		end
		else
			case (state_q)
				D_RX:
					if (frame_end)
						state_q <= D_CHECK;
				D_CHECK:
					if (!frame_ok)
						state_q <= D_RX;
					else if (exc_d != `MRS_EX_NONE)
					begin
						tx_len_q <= 6'h03;
						state_q  <= D_TX;
					end
					else
					begin
						cmd_q   <= r_cmd;
						base_q  <= r_addr;
						cnt_q   <= is_w1 ? `MRS_CNT_MIN : r_cnt;
						state_q <= D_ACCESS;
					end
				D_ACCESS:
					if (acc_done && i_par_status != `MRS_EX_NONE)
					begin
						tx_len_q <= 6'h03;
						state_q  <= D_TX;
					end
					else if (acc_done && acc_q == cnt_q[3:0] - 4'h1)
					begin
						tx_len_q <= q_rd ? 6'(3 + 2 * cnt_q[3:0]) : 6'h06;
						state_q  <= D_TX;
					end
				D_TX:
					if (tx_idx_q == tx_len_q + 6'h01)
						state_q <= D_RX;
				default:
					state_q <= D_RX;
			endcase

	// One store access at a time; the next starts only after the previous acknowledge.
	always_ff @(posedge i_core_clk)
		if (i_reset)
		begin
			o_par_req   <= 1'b0;
			o_par_we    <= 1'b0;
			o_par_nv    <= 1'b0;
			o_par_addr  <= 16'h0000;
			o_par_wdata <= 16'h0000;
			acc_q       <= 4'h0;
			wait_q      <= 1'b0;
		end
		else
		begin
			o_par_req <= 1'b0;
			if (state_q != D_ACCESS)
			begin
				acc_q  <= 4'h0;
				wait_q <= 1'b0;
			end
			else if (!wait_q)
			begin
				o_par_req  <= 1'b1;
				o_par_we   <= !q_rd;
				o_par_nv   <= q_nv ? 1'b1 : i_persist_select;
				o_par_addr <= base_q + {12'h000, acc_q};
				o_par_wdata <= q_w1 ? {rx_buf[4], rx_buf[5]} :
					{rx_buf[5'(7 + 2 * acc_q)], rx_buf[5'(8 + 2 * acc_q)]};
				wait_q     <= 1'b1;
			end
			else if (i_par_ack)
			begin
				wait_q <= 1'b0;
				acc_q  <= acc_q + 4'h1;
			end
		end

	always_ff @(posedge i_core_clk)
		if (state_q == D_CHECK)
		begin
			tx_buf[0] <= i_slave_addr;
			tx_buf[1] <= (exc_d != `MRS_EX_NONE) ? (r_cmd | `MRS_EXC_FLAG) : r_cmd;
			tx_buf[2] <= (exc_d != `MRS_EX_NONE) ? exc_d :
				(is_rd ? {r_cnt[6:0], 1'b0} : rx_buf[2]);
			tx_buf[3] <= rx_buf[3];
			tx_buf[4] <= rx_buf[4];
			tx_buf[5] <= rx_buf[5];
		end
		else if (acc_done)
		begin
			if (i_par_status != `MRS_EX_NONE)
			begin
				tx_buf[1] <= cmd_q | `MRS_EXC_FLAG;
				tx_buf[2] <= i_par_status;
			end
			else if (q_rd)
			begin
				tx_buf[5'(3 + 2 * acc_q)] <= i_par_rdata[15:8];
				tx_buf[5'(4 + 2 * acc_q)] <= i_par_rdata[7:0];
			end
		end

	always_ff @(posedge i_core_clk)
		if (i_reset || state_q != D_TX)
		begin
			tx_idx_q    <= 6'h00;
			tx_crc_q    <= `MRS_CRC_INIT;
			d2h_valid_q <= 1'b0;
			d2h_byte_q  <= 8'h00;
		end
		else
		begin
			d2h_valid_q <= 1'b1;
			tx_idx_q    <= tx_idx_q + 6'h01;
			if (tx_idx_q < tx_len_q)
			begin
				d2h_byte_q <= tx_buf[tx_idx_q[4:0]];
				tx_crc_q   <= mrs_crc_step(tx_crc_q, tx_buf[tx_idx_q[4:0]]);
			end
			else if (tx_idx_q == tx_len_q)
				d2h_byte_q <= tx_crc_q[7:0];
			else
				d2h_byte_q <= tx_crc_q[15:8];
		end

	always_ff @(posedge i_core_clk)
		if (i_reset)
			o_frame_drop <= 1'b0;
		else
			o_frame_drop <= (state_q == D_CHECK) && !frame_ok;
endmodule

// ### test/modbus_rtu_slave_parser_bench.sv
// Bench joining both ends of the RTU link, with a store model and a second drive.
// Assumes the design under hdl/ and the checker are compiled first.
`timescale 1ns/1ps
module modbus_rtu_slave_parser_bench;
	localparam logic [7:0] RQ [8] = '{8'h05, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01, 8'hD5, 8'hB2};
	localparam logic [7:0] RS [7] = '{8'h05, 8'h03, 8'h02, 8'h13, 8'h88, 8'h44, 8'hD2};
	localparam logic [55:0] EX [6] = '{56'h03_1100_0001_00_02, 56'h06_6500_0001_00_20,
		56'h04_0100_0001_00_01, 56'h06_0200_0001_21_21, 56'h03_0100_0000_00_03,
		56'h10_0100_000B_00_03};
	// Raw frames: nine bytes left aligned, byte count, expected exception code.
	localparam logic [87:0] BF [3] = '{{72'h05_0301_0100_0000_0000, 8'd6, 8'h03},
		{72'h05_1001_0100_0103_1234, 8'd9, 8'h17}, {72'h05_0301_0100_0100_0000, 8'd7, 8'h18}};
	localparam int GAP = 20;
	localparam int TMO = 200;
	logic         clk, rst, rv, rdy, rdv, done, nrep, brep, pers, preq, pwe, pnv, pack, drop, drop2;
	logic [7:0]   rsl, rcmd, exc, saddr, pst, st_f;
	logic [15:0]  radr, rcnt, rdd, padr, pwd, prd;
	logic [159:0] rdat;
	logic [15:0]  mem [logic [15:0]];
	logic [7:0]   hq [$];
	logic [7:0]   dq [$];
	logic [7:0]   d2q [$];
	logic [15:0]  rq [$];
	logic [33:0]  wq [$];
	int           failures, n_checks, cyc, ndrop, ndrop2;
	logic [15:0]  crc2;

	mrs_link_if lnk();
	mrs_link_if lnk2();
	mrs_master #(.GAP_CYCLES(GAP), .RSP_TIMEOUT(TMO)) i_mrs_master (.i_core_clk(clk),
		.i_reset(rst), .link(lnk), .i_req_valid(rv), .o_req_ready(rdy), .i_req_slave(rsl),
		.i_req_cmd(rcmd), .i_req_addr(radr), .i_req_cnt(rcnt), .i_req_data(rdat),
		.o_rd_valid(rdv), .o_rd_data(rdd), .o_done(done), .o_exc(exc), .o_no_reply(nrep),
		.o_bad_reply(brep));
	mrs_slave #(.GAP_CYCLES(GAP)) i_mrs_slave (.i_core_clk(clk), .i_reset(rst), .link(lnk),
		.i_slave_addr(saddr), .i_persist_select(pers), .o_par_req(preq), .o_par_we(pwe),
		.o_par_nv(pnv), .o_par_addr(padr), .o_par_wdata(pwd), .i_par_ack(pack),
		.i_par_rdata(prd), .i_par_status(pst), .o_frame_drop(drop));
	// The second drive answers every access at once with the sample register value.
	mrs_slave #(.GAP_CYCLES(GAP)) i_mrs_slave_b (.i_core_clk(clk), .i_reset(rst), .link(lnk2),
		.i_slave_addr(saddr), .i_persist_select(pers), .o_par_req(), .o_par_we(), .o_par_nv(),
		.o_par_addr(), .o_par_wdata(), .i_par_ack(1'b1), .i_par_rdata(16'h1388),
		.i_par_status(8'h00), .o_frame_drop(drop2));
	mrs_assertions #(.GAP_CYCLES(GAP)) i_mrs_assertions (.i_core_clk(clk), .i_reset(rst),
		.h2d_valid(lnk.h2d_valid), .h2d_byte(lnk.h2d_byte), .d2h_valid(lnk.d2h_valid),
		.d2h_byte(lnk.d2h_byte));

	always #2 clk = ~clk;

	always @(posedge clk)
	begin
		#1;
		pack = (preq === 1'b1);
		if (preq === 1'b1)
		begin
			wq.push_back({pwe, pnv, padr, pwd});
			pst = st_f;
			prd = (pwe !== 1'b1) ? mem[padr] : 16'h0000;
			if (pwe === 1'b1 && st_f == 8'h00) mem[padr] = pwd;
		end
	end

	// Sampled on the falling edge, where every pulse of the design has settled.
	always @(negedge clk)
	begin
		if (lnk.h2d_valid === 1'b1) hq.push_back(lnk.h2d_byte);
		if (lnk.d2h_valid === 1'b1) dq.push_back(lnk.d2h_byte);
		if (lnk2.d2h_valid === 1'b1) d2q.push_back(lnk2.d2h_byte);
		if (drop === 1'b1) ndrop++;
		if (drop2 === 1'b1) ndrop2++;
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			results();
		end
	end

	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Own checksum step, kept apart from the design so a shared slip shows.
	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
		return r;
	endfunction

	// Sends n bytes of f to the second drive, then a good checksum and a long silence.
	task automatic raw(input logic [71:0] f, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		d2q = {};
		for (int i = 0; i < n + 2; i++)
		begin
			lnk2.h2d_valid = 1'b1;
			lnk2.h2d_byte = (i < n) ? f[71 - 8*i -: 8] : ((i == n) ? c[7:0] : c[15:8]);
			if (i < n)
				c = crc_b(c, lnk2.h2d_byte);
			@(posedge clk);
			#1;
		end
		{lnk2.h2d_valid, lnk2.h2d_byte} = 9'h000;
		repeat (60) @(posedge clk);
		#1;
	endtask

	task automatic req(input logic [7:0] sl, cm, input logic [15:0] ad, cn);
		int n;
		n = 0;
		hq = {};
		dq = {};
		rq = {};
		wq = {};
		while (rdy !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		{rsl, rcmd, radr, rcnt, rv} = {sl, cm, ad, cn, 1'b1};
		do
		begin
			@(posedge clk);
			#1;
			rv = 1'b0;
			if (rdv === 1'b1) rq.push_back(rdd);
			n++;
		end
		while (done !== 1'b1 && n < 4000);
		chk(done, 1'b1);
	endtask

	task automatic results();
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		{clk, rst, rv, rsl, rcmd, radr, rcnt, rdat, pers, pack, prd, pst, st_f} = '0;
		rst = 1'b1;
		saddr = 8'h05;
		{lnk2.h2d_valid, lnk2.h2d_byte} = 9'h000;
		{failures, n_checks, cyc, ndrop, ndrop2} = '0;
		mem[16'h0101] = 16'h1388;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		req(8'h05, 8'h03, 16'h0101, 16'h0001);
		foreach (RQ[i]) chk(hq[i], RQ[i]);
		foreach (RS[i]) chk(dq[i], RS[i]);
		chk({exc, rq.size(), rq[0]}, {8'h00, 32'd1, 16'h1388});
		for (int k = 0; k < 4; k++)
		begin
			pers = k[0];
			req(8'h05, k[1] ? 8'h41 : 8'h06, 16'h6400 + 16'(k), 16'h0A50 + 16'(k));
			chk({exc, wq.size()}, {8'h00, 32'd1});
			chk(wq[0], {1'b1, k[1] | k[0], 16'h6400 + 16'(k),
				16'h0A50 + 16'(k)});
		end
		pers = 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			for (int i = 0; i < 10; i++) rdat[16*i +: 16] = 16'hC000 + 16'(k*16+i);
			req(8'h05, k ? 8'h43 : 8'h10, k ? 16'h1200 : 16'h1700, k ? 16'h0002 : 16'h000A);
			chk({exc, wq.size()}, {8'h00, k ? 32'd2 : 32'd10});
			foreach (wq[i])
				chk(wq[i], {1'b1, k[0], (k ? 16'h1200 : 16'h1700) + 16'(i),
					16'hC000 + 16'(k*16+i)});
		end
		req(8'h05, 8'h03, 16'h1700, 16'h000A);
		chk({dq.size(), rq.size()}, {32'd25, 32'd10});
		foreach (rq[i]) chk(rq[i], 16'hC000 + 16'(i));
		foreach (EX[j])
		begin
			st_f = EX[j][15:8];
			req(8'h05, EX[j][55:48], EX[j][47:32], EX[j][31:16]);
			chk({exc, brep}, {EX[j][7:0], 1'b0});
		end
		st_f = 8'h00;
		for (int k = 0; k < 2; k++)
		begin
			req(k ? 8'h06 : 8'h00, 8'h06, 16'h0300, 16'h5555);
			chk({nrep, dq.size(), wq.size()}, {1'b1, 64'd0});
		end
		chk(ndrop, 2);
		// A bad frame, one bare gap with a little slack, then a good frame.
		for (int k = 0; k < 2; k++)
		begin
			foreach (RQ[i])
			begin
				lnk2.h2d_valid = 1'b1;
				lnk2.h2d_byte = (k == 0 && i == 7) ? 8'hB3 : RQ[i];
				@(posedge clk);
				#1;
			end
			{lnk2.h2d_valid, lnk2.h2d_byte} = 9'h000;
			repeat (k ? 60 : 23) @(posedge clk);
			#1;
		end
		chk({ndrop2, d2q.size()}, {32'd1, 32'd7});
		foreach (RS[i]) chk(d2q[i], RS[i]);
		// The host end filters these faults, so they go straight to the second drive.
		foreach (BF[j])
		begin
			raw(BF[j][87:16], int'(BF[j][15:8]));
			crc2 = 16'hFFFF;
			foreach (d2q[i]) crc2 = crc_b(crc2, d2q[i]);
			chk({d2q.size(), d2q[0], d2q[1], d2q[2], crc2},
				{32'd5, 8'h05, 1'b1, BF[j][78:72], BF[j][7:0], 16'h0000});
		end
		results();
	end
endmodule

// ### test/mrs_assertions.sv
// Checker for the byte link that joins the host end and the drive end.
// Assumes one clock for both ends and the chars of one frame back to back.
`timescale 1ns/1ps
module mrs_assertions
#(
	parameter int unsigned GAP_CYCLES = 20
)(
	input logic       i_core_clk,
	input logic       i_reset,
	input logic       h2d_valid,
	input logic [7:0] h2d_byte,
	input logic       d2h_valid,
	input logic [7:0] d2h_byte
);
	logic [7:0]  hb_q [8];
	logic [7:0]  db_q [8];
	logic        hv_q;
	logic        dv_q;
	logic [5:0]  hn_q;
	logic [5:0]  dn_q;
	logic [15:0] hc_q;
	logic [15:0] dc_q;
	logic [31:0] sil_q;
	wire         h_end = hv_q && !h2d_valid;
	wire         d_end = dv_q && !d2h_valid;

	// Own copy of the checksum step, so a shared slip cannot hide itself.
	function automatic logic [15:0] crc_nx(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
		return r;
	endfunction

	always_ff @(posedge i_core_clk)
	begin
		hv_q <= i_reset ? 1'b0 : h2d_valid;
		dv_q <= i_reset ? 1'b0 : d2h_valid;
		sil_q <= (i_reset || h2d_valid || d2h_valid) ? 32'h0000_0000 : sil_q + 32'h0000_0001;
	end

	// Only the first eight bytes are kept; later ones are counted and summed.
	always_ff @(posedge i_core_clk)
	begin
		if (h2d_valid)
		begin
			hn_q <= hv_q ? hn_q + 6'h01 : 6'h01;
			hc_q <= crc_nx(hv_q ? hc_q : 16'hFFFF, h2d_byte);
			if (!hv_q || hn_q < 6'h08)
				hb_q[hv_q ? hn_q[2:0] : 3'h0] <= h2d_byte;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (d2h_valid)
		begin
			dn_q <= dv_q ? dn_q + 6'h01 : 6'h01;
			dc_q <= crc_nx(dv_q ? dc_q : 16'hFFFF, d2h_byte);
			if (!dv_q || dn_q < 6'h08)
				db_q[dv_q ? dn_q[2:0] : 3'h0] <= d2h_byte;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	property p_half_duplex;
		!(h2d_valid && d2h_valid);
	endproperty
	a_half_duplex: assert property (p_half_duplex) else $error("both ends drive");
	property p_req_gap;
		h2d_valid && !hv_q |-> sil_q >= GAP_CYCLES;
	endproperty
	a_req_gap: assert property (p_req_gap) else $error("request gap short");
	property p_rsp_gap;
		d2h_valid && !dv_q |-> sil_q >= GAP_CYCLES && hb_q[0] != 8'h00;
	endproperty
	a_rsp_gap: assert property (p_rsp_gap) else $error("bad answer start");
	property p_req_crc;
		h_end |-> hc_q == 16'h0000;
	endproperty
	a_req_crc: assert property (p_req_crc) else $error("request checksum");
	property p_rsp_crc;
		d_end |-> dc_q == 16'h0000 && db_q[0] == hb_q[0] && db_q[1][6:0] == hb_q[1][6:0];
	endproperty
	a_rsp_crc: assert property (p_rsp_crc) else $error("answer head or sum");
	property p_exc_frame;
		d_end && db_q[1][7] |-> dn_q == 6'h05 && db_q[2] inside {8'h01, 8'h02, 8'h03, 8'h04,
			8'h05, 8'h06, 8'h16, 8'h17, 8'h18, 8'h20, 8'h21, 8'h22};
	endproperty
	a_exc_frame: assert property (p_exc_frame) else $error("exception frame");
	property p_rd_rsp;
		d_end && db_q[1] == 8'h03 |-> db_q[2] == {hb_q[5][6:0], 1'b0} &&
			dn_q == db_q[2][5:0] + 6'h05;
	endproperty
	a_rd_rsp: assert property (p_rd_rsp) else $error("read answer");
	property p_wr_rsp;
		d_end && db_q[1] inside {8'h06, 8'h10, 8'h41, 8'h43} |-> dn_q == 6'h08 &&
			{db_q[2], db_q[3], db_q[4], db_q[5]} == {hb_q[2], hb_q[3], hb_q[4], hb_q[5]};
	endproperty
	a_wr_rsp: assert property (p_wr_rsp) else $error("write answer");
	property p_wrn_req;
		h_end && hb_q[1] inside {8'h10, 8'h43} |-> hb_q[6] == {hb_q[5][6:0], 1'b0} &&
			hn_q == hb_q[6][5:0] + 6'h09;
	endproperty
	a_wrn_req: assert property (p_wrn_req) else $error("write request");
endmodule
